// ===== xfer_pkg.sv
/*
 * Package for the execution-phase transfer controller: timing counts,
 * status flag positions, reset values and the carrier structs.
 * Assumes a single 250 MHz clock.
 */
// Behaviour
// - Read request when occupancy reaches 16 minus threshold
// - Burst read holds request until FIFO empty
// - Non-burst read drops, re-requests after 350 ns
// - Last byte removed drops request until trigger
// - Sector end forces read request below threshold
// - Write request when occupancy at most threshold
// - Burst write holds request until FIFO full
// - Non-burst write drops, re-requests after 350 ns
// - Sector's last written byte drops request
// - Burst end seen on acknowledge or strobe
// - Request removed within 50 ns of strobe
// - Bare acknowledge pulse counts one byte
// - Missed service ends execution with error
// - Underrun pads sector with last byte, CRC
// - End interrupt until first result byte read
// - FIFO-less interrupt mode: per-byte interrupt, flags
// - Host transfer needs select with read/write
// - Last host byte: interrupt, request and direction
// - FIFO interrupt mode follows request triggers
// - Status shows execution until FIFO drained
// - Request flag mirrors interrupt line
// - DMA cycles ignore select and address
// - Terminal count honoured only with acknowledge
package xfer_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_PS    = 4000;
    localparam int REARM_NS         = 350;
    // Least time, rounded up to whole cycles
    localparam int REARM_CYCLES     = (REARM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DROP_LIMIT_NS    = 50;
    // Longest time, rounded down; the design drops in one cycle
    localparam int DROP_LIMIT_CYC   = (DROP_LIMIT_NS * 1000) / CLK_PERIOD_PS;
    localparam int SERVICE_CYCLES   = 4000;

    // ==========================================================
    // FIFO and status layout
    // ==========================================================
    localparam int       FIFO_DEPTH       = 16;
    localparam int       OCC_W            = 5;
    localparam int       STATUS_REQ_BIT   = 7;
    localparam int       STATUS_DIR_BIT   = 6;
    localparam int       STATUS_NDMA_BIT  = 5;
    localparam int       STATUS_BUSY_BIT  = 4;
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam logic [3:0] FIFO_THRESHOLD_RESET   = 4'h0;

    // Configuration set by software before a command
    typedef struct packed {
        logic       fifo_enable;
        logic       burst;
        logic       dma_mode;
        logic [3:0] fifo_threshold;
    } xfer_cfg_type;

    // Host and DMA strobes, already decoded to active high
    typedef struct packed {
        logic dack;
        logic rd;
        logic wr;
        logic cs;
        logic addr_ok;
        logic tc;
    } host_bus_type;

endpackage

// ===== rearm_timer.sv
/*
 * Re-arm timer: after a start pulse it counts a fixed number of cycles
 * and then raises done for one cycle. Assumes one clock.
 */
`timescale 1ns/10ps
module rearm_timer #(
    parameter int CYCLES = 88
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Control
    input  wire logic start,
    input  wire logic cancel,
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count;   // Cycles remaining

    // ==========================================================
    // Down counter
    // ==========================================================
    // Start restarts the count; cancel abandons it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (cancel) begin
                count <= '0;
            end else if (start) begin
                count <= CW'(CYCLES);
            end else if (count != '0) begin
                count <= count - 1'b1;
                done  <= (count == CW'(1));
            end
        end
    end

    assign busy = (count != '0);

endmodule

// ===== sector_counter.sv
/*
 * Sector byte counter: counts bytes against a sector length and flags
 * the last one. Assumes the length is stable during a sector.
 */
`timescale 1ns/10ps
module sector_counter #(
    parameter int LEN_W = 11
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Control
    input  wire logic             clear,
    input  wire logic             step,
    input  wire logic [LEN_W-1:0] sector_len,
    output logic [LEN_W-1:0]      count,
    output logic                  last
);
    // ==========================================================
    // Counter
    // ==========================================================
    // Last is high while the next step takes the final byte
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (step) begin
            count <= count + 1'b1;
        end
    end

    assign last = (count + 1'b1 == sector_len);

endmodule

// ===== xfer_ctrl.sv
/*
 * Execution-phase transfer control: DMA request or host interrupt from
 * FIFO occupancy, sector counting, overrun/underrun sequencing and the
 * main status flags. The FIFO storage itself lies outside; this block
 * sees its occupancy and the disk side's byte events. Host strobes are
 * active high, decoded and synchronous to clk.
 */
`timescale 1ns/10ps
module xfer_ctrl #(
    parameter int LEN_W   = 11,
    parameter int SERVICE = xfer_pkg::SERVICE_CYCLES
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Configuration
    input  wire xfer_pkg::xfer_cfg_type cfg,
    input  wire logic [LEN_W-1:0]      sector_len,
    input  wire logic                  write_dir,
    // Command sequencing
    input  wire logic                  exec_start,
    input  wire logic                  more_sectors,
    input  wire logic                  result_read,
    // Host and DMA bus
    input  wire xfer_pkg::host_bus_type bus,
    // FIFO and disk side
    input  wire logic [4:0]            fifo_count,
    input  wire logic                  disk_byte,
    input  wire logic [7:0]            host_wdata,
    // Outputs
    output logic                       drq,
    output logic                       fdc_interrupt,
    output logic [7:0]                 main_status_reg,
    output logic                       error_flag,
    output logic                       pad_write,
    output logic [7:0]                 pad_data,
    output logic                       crc_append
);
    // States of execution
    typedef enum logic [2:0] {
        IDLE_S, EXEC_S, DRAIN_S, PAD_S, RESULT_S
    } phase_type;

    phase_type phase;
    phase_type next_phase;

    logic [7:0] last_byte;       // Last good written byte
    logic       req;             // Request level before mode steering
    logic       next_req;
    logic       run;             // A request series is under way
    logic       strobe_d;        // Previous strobe level
    logic       dack_d;          // Previous acknowledge level
    logic       sector_done;     // Sector boundary reached
    logic [$clog2(SERVICE+1)-1:0] wait_cnt; // Service timer

    // ==========================================================
    // Transfer recognition
    // ==========================================================
    wire dma_sel    = cfg.dma_mode & bus.dack;
    wire dma_xfer   = dma_sel;
    wire host_xfer  = !cfg.dma_mode & bus.cs & bus.addr_ok & (bus.rd | bus.wr);
    wire strobe     = bus.rd | bus.wr;
    wire any_xfer   = dma_xfer | host_xfer;
    // bare acknowledge pulse is one byte
    wire dack_lead  = bus.dack & !dack_d;
    wire trail      = strobe_d & !strobe;
    wire byte_done  = cfg.dma_mode ? (dack_lead | (bus.dack & trail)) : (host_xfer & !strobe_d);
    wire lead_edge  = (bus.dack & !dack_d) | (strobe & !strobe_d);
    wire tc_hit     = bus.tc & bus.dack;

    wire [4:0] thr5  = {1'b0, (cfg.fifo_enable ? cfg.fifo_threshold : 4'hf)};
    wire rd_trig    = fifo_count >= 5'(xfer_pkg::FIFO_DEPTH) - thr5;
    wire wr_trig    = fifo_count <= thr5;
    wire fifo_empty = fifo_count == 5'h0_0;
    wire fifo_full  = fifo_count == 5'(xfer_pkg::FIFO_DEPTH);

    // Sector counting of host-side bytes, pad bytes included, and of disk-side bytes
    logic [LEN_W-1:0] sec_cnt;
    logic             sec_last;
    logic             disk_last;
    logic [LEN_W-1:0] disk_cnt;
    sector_counter #(.LEN_W(LEN_W)) host_sector (
        .clk        (clk),
        .rstn       (rstn),
        .clear      (exec_start | (sector_done & more_sectors)),
        .step       ((byte_done & (phase == EXEC_S | phase == DRAIN_S)) | pad_write),
        .sector_len (sector_len),
        .count      (sec_cnt),
        .last       (sec_last)
    );
    sector_counter #(.LEN_W(LEN_W)) disk_sector (
        .clk        (clk),
        .rstn       (rstn),
        .clear      (exec_start | (sector_done & more_sectors)),
        .step       (disk_byte),
        .sector_len (sector_len),
        .count      (disk_cnt),
        .last       (disk_last)
    );

    // Non-burst re-arm delay
    logic rearm_busy;
    wire  nb_start = !cfg.burst & byte_done & (phase == EXEC_S);
    rearm_timer #(.CYCLES(xfer_pkg::REARM_CYCLES)) rearm (
        .clk    (clk),
        .rstn   (rstn),
        .start  (nb_start),
        .cancel (exec_start),
        .busy   (rearm_busy),
        .done   ()
    );

    // all disk bytes in, force request
    wire sector_in  = (disk_cnt == sector_len) & (sector_len != '0);
    wire wr_sec_end = write_dir & byte_done & sec_last;
    wire rd_sec_end = !write_dir & byte_done & sec_last;
    wire timeout    = wait_cnt == '0;
    // A series lasts until drained (read), or filled or sector done (write)
    wire wr_end     = fifo_full | sector_done
                    | (byte_done & fifo_count == 5'(xfer_pkg::FIFO_DEPTH - 1));
    wire rd_end     = fifo_empty | (byte_done & fifo_count == 5'h01);
    wire run_end    = write_dir ? wr_end : rd_end;

    // ==========================================================
    // Request level
    // ==========================================================
    always_comb begin
        next_req = req;
        if (phase != EXEC_S) begin
            next_req = 1'b0;
        end else if (!write_dir) begin
            if (fifo_empty | (byte_done & fifo_count == 5'h0_1)) begin
                next_req = 1'b0;
            end else if (!cfg.burst & (lead_edge | rearm_busy)) begin
                next_req = 1'b0;
            end else if (rd_trig | sector_in | run) begin
                // A started series re-arms while data remains
                next_req = 1'b1;
            end
        end else begin
            if (wr_sec_end | sector_done) begin
                next_req = 1'b0;
            end else if (fifo_full | (byte_done & fifo_count == 5'(xfer_pkg::FIFO_DEPTH - 1))) begin
                next_req = 1'b0;
            end else if (!cfg.burst & (lead_edge | rearm_busy)) begin
                next_req = 1'b0;
            end else if (wr_trig | (req & cfg.burst) | run) begin
                // A started series re-arms until the FIFO is full
                next_req = 1'b1;
            end
        end
        // burst read keeps request while data
        if (phase == EXEC_S & !write_dir & cfg.burst & req & !fifo_empty
            & !(byte_done & fifo_count == 5'h0_1)) begin
            next_req = 1'b1;
        end
        if (cfg.burst & lead_edge & (tc_hit | (write_dir & sec_last))) begin
            next_req = 1'b0;
        end
    end

    // ==========================================================
    // Phase sequencing
    // ==========================================================
    always_comb begin
        next_phase  = phase;
        sector_done = 1'b0;
        unique case (phase)
            IDLE_S: begin
                if (exec_start) begin
                    next_phase = EXEC_S;
                end
            end
            EXEC_S: begin
                if (write_dir & timeout) begin
                    next_phase = PAD_S;
                end else if (!write_dir & timeout) begin
                    next_phase = DRAIN_S;
                end else if (wr_sec_end | rd_sec_end | tc_hit) begin
                    sector_done = 1'b1;
                    if (!more_sectors | tc_hit) begin
                        next_phase = RESULT_S;
                    end
                end
            end
            DRAIN_S: begin
                if (rd_sec_end | (sector_in & fifo_empty)) begin
                    next_phase = RESULT_S;
                end
            end
            PAD_S: begin
                if (sec_last & pad_write) begin
                    next_phase = RESULT_S;
                end
            end
            RESULT_S: begin
                if (result_read) begin
                    next_phase = IDLE_S;
                end
            end
            default: next_phase = IDLE_S;
        endcase
    end

    // ==========================================================
    // State registers
    // ==========================================================
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase    <= IDLE_S;
            req      <= 1'b0;
            run      <= 1'b0;
            strobe_d <= 1'b0;
            dack_d   <= 1'b0;
        end else begin
            phase    <= next_phase;
            req      <= next_req;
            run      <= (next_phase == EXEC_S) & (next_req | run) & !run_end;
            strobe_d <= strobe;
            dack_d   <= bus.dack;
        end
    end

    // Service timer restarts on each transfer; it waits while idle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_cnt <= '1;
        end else if (phase != EXEC_S | any_xfer | !req) begin
            wait_cnt <= ($clog2(SERVICE+1))'(SERVICE);
        end else if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
        end
    end

    // ==========================================================
    // Underrun padding and error
    // ==========================================================
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_byte  <= 8'h00;
            pad_write  <= 1'b0;
            crc_append <= 1'b0;
            error_flag <= 1'b0;
        end else begin
            if (write_dir & byte_done & phase == EXEC_S) begin
                last_byte <= host_wdata;
            end
            pad_write  <= (next_phase == PAD_S) & !(pad_write & sec_last);
            crc_append <= (phase == PAD_S) & (next_phase == RESULT_S);
            // error flagged into result
            // A timeout wins over a clear in the same cycle
            if (phase == EXEC_S & timeout) begin
                error_flag <= 1'b1;
            end else if (exec_start) begin
                error_flag <= 1'b0;
            end
        end
    end
    assign pad_data = last_byte;

    // ==========================================================
    // Outputs: request, interrupt, status
    // ==========================================================
    wire host_mode = !cfg.dma_mode;
    wire data_irq  = host_mode & next_req;
    wire end_irq   = next_phase == RESULT_S;
    wire in_exec   = next_phase == EXEC_S | next_phase == DRAIN_S | next_phase == PAD_S;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drq             <= 1'b0;
            fdc_interrupt   <= 1'b0;
            main_status_reg <= xfer_pkg::STATUS_RESET;
        end else begin
            // dropped one cycle after the edge
            drq           <= cfg.dma_mode & next_req;
            fdc_interrupt <= data_irq | end_irq;
            main_status_reg[xfer_pkg::STATUS_REQ_BIT]  <= host_mode ? (data_irq | end_irq) : end_irq;
            main_status_reg[xfer_pkg::STATUS_DIR_BIT]  <= end_irq | (in_exec & !write_dir);
            main_status_reg[xfer_pkg::STATUS_NDMA_BIT] <= host_mode & in_exec;
            main_status_reg[xfer_pkg::STATUS_BUSY_BIT] <= next_phase != IDLE_S;
            main_status_reg[3:0]                        <= 4'h0;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    drq_drop_a: assert property (@(posedge clk) disable iff (!rstn)
        (drq & !cfg.burst & lead_edge & phase == EXEC_S) |=> !drq)
        else $error("request not dropped after strobe");
    end_irq_a: assert property (@(posedge clk) disable iff (!rstn)
        (phase == RESULT_S & !result_read) |=> fdc_interrupt)
        else $error("end interrupt missing in result phase");
    rd_empty_a: assert property (@(posedge clk) disable iff (!rstn)
        (!write_dir & fifo_empty & phase == EXEC_S) |=> !drq)
        else $error("read request while FIFO empty");
    mirror_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        !cfg.dma_mode |-> main_status_reg[7] == fdc_interrupt)
        else $error("request flag not mirroring interrupt");
    tc_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        (phase == EXEC_S & bus.tc & !bus.dack & !timeout & !wr_sec_end & !rd_sec_end)
        |=> phase == EXEC_S)
        else $error("terminal count taken without acknowledge");
    nb_gap_a: assert property (@(posedge clk) disable iff (!rstn)
        (nb_start & !write_dir) |=> !drq [*2])
        else $error("non-burst request reasserted too soon");
    wr_sec_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_sec_end |=> !drq)
        else $error("write request held after sector end");
    pad_end_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(crc_append) |-> phase == RESULT_S)
        else $error("CRC append outside pad completion");

endmodule

// ===== dma_partner.sv
/*
 * Behavioural DMA controller with the FIFO occupancy it sees, for the
 * transfer controller bench. Assumes one clock and active-high strobes.
 */
`timescale 1ns/10ps
module dma_partner #(
    parameter int DELAY = 3
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Device side
    input  wire logic       drq,
    input  wire logic       write_dir,
    output logic            dack,
    output logic [4:0]      fifo_count,
    // Bench control
    input  wire logic       load,
    input  wire logic [4:0] load_val,
    input  var  int         limit
);
    // ==========================================================
    // Acknowledge engine
    // ==========================================================
    int served;   // Bytes moved since the last load
    int wait_cnt; // Cycles drq has been seen before answering

    // Waiting DELAY cycles lets a stale drq settle, so no surplus byte
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dack       <= 1'b0;
            served     <= 0;
            wait_cnt   <= 0;
            fifo_count <= 5'h00;
        end else if (load) begin
            fifo_count <= load_val;
            served     <= 0;
            dack       <= 1'b0;
        end else if (dack) begin
            dack       <= 1'b0;
            fifo_count <= write_dir ? fifo_count + 5'h01 : fifo_count - 5'h01;
        end else if (drq && served < limit) begin
            if (wait_cnt >= DELAY) begin
                dack     <= 1'b1;
                served   <= served + 1;
                wait_cnt <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end else begin
            wait_cnt <= 0;
        end
    end
endmodule

// ===== tb.sv
/*
 * Self-checking bench for xfer_ctrl: DMA reads and writes, underrun
 * and host mode. Assumes dma_partner models the DMA side and FIFO.
 */
`timescale 1ns/10ps
module tb;
    // ==========================================================
    // Signals
    // ==========================================================
    logic                   clk, rstn, exec_start, result_read, disk_byte;
    logic                   load, write_dir, rd, cs, addr_ok, dack, drq;
    logic                   fdc_interrupt, error_flag, pad_write, crc_append;
    logic [7:0]             host_wdata, main_status_reg, pad_data;
    logic [10:0]            sector_len;
    logic [4:0]             fifo_count, load_val;
    xfer_pkg::xfer_cfg_type cfg;
    xfer_pkg::host_bus_type bus;
    int                     limit, mismatches, n_tests, n, k;
    logic [10:0]            lens [2] = '{11'h004, 11'h200};
    logic [4:0]             loads [2] = '{5'h00, 5'h0A};
    logic [7:0]             fills [2] = '{8'h04, 8'h10};

    // Write strobe and terminal count stay idle here
    assign bus = '{dack: dack, rd: rd, wr: 1'b0, cs: cs, addr_ok: addr_ok, tc: 1'b0};

    // ==========================================================
    // Instances
    // ==========================================================
    xfer_ctrl #(.LEN_W(11), .SERVICE(200)) uut (
        .clk(clk), .rstn(rstn), .cfg(cfg), .sector_len(sector_len),
        .write_dir(write_dir), .exec_start(exec_start), .more_sectors(1'b0),
        .result_read(result_read), .bus(bus), .fifo_count(fifo_count),
        .disk_byte(disk_byte), .host_wdata(host_wdata), .drq(drq),
        .fdc_interrupt(fdc_interrupt), .main_status_reg(main_status_reg),
        .error_flag(error_flag), .pad_write(pad_write), .pad_data(pad_data),
        .crc_append(crc_append));
    dma_partner partner (
        .clk(clk), .rstn(rstn), .drq(drq), .write_dir(write_dir), .dack(dack),
        .fifo_count(fifo_count), .load(load), .load_val(load_val), .limit(limit));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic sel(input int w);
        case (w)
            1: return fdc_interrupt;
            2: return pad_write;
            3: return crc_append;
            4: return main_status_reg[6];
            5: return dack;
            default: return drq;
        endcase
    endfunction
    // Bounded wait for a flag, then a check that it came
    task automatic wait_hi(input int w, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            if (sel(w) === 1'b1) break;
        end
        chk1(sel(w), 1'b1);
    endtask
    task automatic cycles(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic pulse_disk;
        @(posedge clk);
        disk_byte <= 1'b1;
        @(posedge clk);
        disk_byte <= 1'b0;
    endtask
    task automatic set_count(input logic [4:0] v, input int lim);
        @(posedge clk);
        load     <= 1'b1;
        load_val <= v;
        limit    <= lim;
        @(posedge clk);
        load <= 1'b0;
        #1;
    endtask
    // One data register read by the host; the FIFO occupancy is loaded with zero
    task automatic host_read;
        @(posedge clk);
        {cs, addr_ok, rd, load, load_val} <= {4'hF, 5'h00};
        @(posedge clk);
        {cs, addr_ok, rd, load} <= 4'h0;
    endtask
    // Reset, configure, preset occupancy, then start execution
    task automatic start(input logic [2:0] m, input logic [3:0] th, input logic wd,
                         input logic [10:0] len, input logic [4:0] lv, input int lim);
        @(posedge clk);
        rstn       <= 1'b0;
        cfg        <= {m, th};
        write_dir  <= wd;
        sector_len <= len;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        set_count(lv, lim);
        @(posedge clk);
        exec_start <= 1'b1;
        @(posedge clk);
        exec_start <= 1'b0;
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        {rstn, exec_start, result_read, disk_byte, load, write_dir} = '0;
        {rd, cs, addr_ok, load_val, host_wdata, cfg} = '0;
        sector_len = 11'h000;
        {limit, mismatches, n_tests} = '0;
        cycles(6);
        chk8({drq, fdc_interrupt, error_flag, pad_write, crc_append, 3'h0}, 8'h00);
        chk8(main_status_reg, xfer_pkg::STATUS_RESET);
        $display("Test reset done");
        start(3'b111, 4'h3, 1'b0, 11'h014, 5'h0C, 0);
        cycles(10);
        chk1(drq, 1'b0);
        set_count(5'h0D, 0);
        wait_hi(0, 10);
        @(posedge clk);
        limit <= 20;
        for (n = 0; fifo_count !== 5'h00 && n < 300; n++) cycles(1);
        chk1(n < xfer_pkg::REARM_CYCLES, 1'b1);
        cycles(3);
        chk1(drq, 1'b0);
        start(3'b111, 4'h3, 1'b0, 11'h002, 5'h02, 0);
        pulse_disk();
        pulse_disk();
        wait_hi(0, 20);
        $display("Test burst read done");
        start(3'b101, 4'h3, 1'b0, 11'h200, 5'h0E, 1);
        wait_hi(5, 40);
        cycles(2);
        chk1(drq, 1'b0);
        for (n = 2; drq !== 1'b1 && n < 300; n++) cycles(1);
        chk1(n >= xfer_pkg::REARM_CYCLES && n <= xfer_pkg::REARM_CYCLES + 4, 1'b1);
        $display("Test non-burst read done");
        start(3'b101, 4'h3, 1'b1, 11'h200, 5'h04, 0);
        cycles(10);
        chk1(drq, 1'b0);
        set_count(5'h03, 1);
        wait_hi(5, 20);
        cycles(2);
        chk1(drq, 1'b0);
        wait_hi(0, 200);
        for (k = 0; k < 2; k++) begin
            start(3'b111, 4'hF, 1'b1, lens[k], loads[k], 20);
            cycles(60);
            chk8({3'h0, fifo_count}, fills[k]);
            chk1(drq, 1'b0);
        end
        $display("Test write done");
        host_wdata <= 8'h5A;
        start(3'b111, 4'hF, 1'b1, 11'h008, 5'h00, 2);
        wait_hi(2, 800);
        chk8(pad_data, 8'h5A);
        chk1(error_flag, 1'b1);
        wait_hi(3, 100);
        wait_hi(1, 100);
        @(posedge clk);
        result_read <= 1'b1;
        @(posedge clk);
        result_read <= 1'b0;
        cycles(2);
        chk1(fdc_interrupt, 1'b0);
        $display("Test underrun done");
        start(3'b000, 4'h0, 1'b0, 11'h001, 5'h01, 0);
        pulse_disk();
        wait_hi(1, 20);
        chk8(main_status_reg & 8'hA0, 8'hA0);
        chk1(main_status_reg[7], 1'b1);
        @(posedge clk);
        cs <= 1'b1;
        cycles(3);
        chk1(fdc_interrupt, 1'b1);
        host_read();
        wait_hi(4, 50);
        chk8(main_status_reg & 8'hF0, 8'hD0);
        chk1(fdc_interrupt, 1'b1);
        $display("Test host mode done");
        start(3'b000, 4'h0, 1'b0, 11'h001, 5'h01, 0);
        wait_hi(1, 20);
        cycles(210);
        chk8({fdc_interrupt, error_flag, 6'h00}, 8'h40);
        host_read();
        wait_hi(1, 20);
        $display("Test read overrun done");
        end_sim();
    end

    // Watchdog far beyond the thousand or so cycles the tests need
    initial begin
        #(4 * 30000);
        mismatches++;
        end_sim();
    end
endmodule
